// ---- asq_sequencer.sv ----
// Functional notes
// RULE_01: Four sequencers: 8, 4, 4, 1 steps.
// RULE_02: Queue word 32 bits, result low 10.
// RULE_03: Each step has select and control nibble.
// RULE_04: Select nibble picks converted analog input.
// RULE_05: Control nibble: temp, irq, last, differential.
// RULE_06: Sequencer runs only when run bit set.
// RULE_07: Same input may repeat within sequence.
// RULE_08: Flagged step completion raises raw interrupt.
// RULE_09: Sequence stops after step marked last.
// RULE_10: Circular queue, each read pops oldest.
// RULE_11: Status shows head, tail, full, empty.
// RULE_12: Overflow and underflow kept in registers.
// RULE_13: Logic runs on the converter clock.
// RULE_14: Ten-bit results, eight inputs plus temperature.
// RULE_15: Interrupt output needs raw and mask set.
// RULE_16: Raw status ignores the mask.
// RULE_17: Masked status is raw AND mask.
// RULE_18: Writing one clears raw; zero ignored.
// RULE_19: Averager sums up to 64 conversions.
// RULE_20: Per-sequencer selectable trigger source and priority.
// RULE_21: Lower priority value served first; 0 default. Reset loads PRIO_RST, priority 0, 1, 2, 3 for sequencers 0 to 3.
// RULE_22: Differential pair n converts inputs 2n, 2n+1.
// RULE_23: Software initiate bit triggers its sequencer.
// RULE_24: Averager off after reset.
// RULE_25: Full queue drops result; empty read flags.
// RULE_26: Steps run back to back from zero.
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module asq_sequencer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [3:0] trig_src,
    output asq_pkg::asq_conv_cmd_t conv_cmd,
    input wire logic conv_done,
    input wire logic [9:0] conv_result,
    output logic irq
);
    import asq_pkg::*;

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed {
        logic [3:0] run;
        logic [3:0] mask;
        logic [3:0] raw;
        logic [3:0] ovf;
        logic [3:0] unf;
        logic [15:0] trig_sel;
        logic [15:0] prio;
        logic [2:0] avg;
        logic [3:0][31:0] mux;
        logic [3:0][31:0] ctl;
        logic [3:0][7:0][9:0] mem;
        logic [3:0][2:0] head;
        logic [3:0][2:0] tail;
        logic [3:0][3:0] cnt;
        logic [3:0] pend;
        logic [1:0] cur;
        logic [2:0] step;
        logic [6:0] avg_cnt;
        logic [15:0] acc;
        asq_fsm_t fsm;
        asq_conv_cmd_t cmd;
        logic [3:0] sy1;
        logic [3:0] sy2;
        logic [3:0] sy3;
        logic aw_got;
        logic w_got;
        logic [11:0] aw_a;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic irq;
    } asq_state_t;

    asq_state_t s_r;
    asq_state_t s_nxt;

    logic [3:0] ev;
    logic [3:0] push;
    logic [3:0] pop;
    logic [3:0] sw_set;
    logic [31:0] wm;
    logic [31:0] bm;
    logic [31:0] rd;
    logic [1:0] q;
    logic [3:0] nib_mux;
    logic [3:0] nib_ctl;
    logic [15:0] acc_sum;
    logic [9:0] avg_val;
    logic [6:0] avg_n;
    logic found;
    logic [1:0] best;
    logic [1:0] bestp;

    // ****************************************************************
    // Helpers.
    // ****************************************************************
    function automatic logic seq_hit(input logic [11:0] a);
        seq_hit = (a[11:7] == OFF_SEQ_BASE[11:7]);
    endfunction : seq_hit

    function automatic logic [31:0] byte_mask(input logic [3:0] strb);
        for (int b = 0; b < 4; b++) begin
            byte_mask[8*b +: 8] = {8{strb[b]}};
        end
    endfunction : byte_mask

    function automatic logic trig_hit(input logic [3:0] sel, input logic [3:0] e);
        case (sel)
            TRIG_COMP: trig_hit = e[SRC_COMP];
            TRIG_GPIO: trig_hit = e[SRC_GPIO];
            TRIG_TIMER: trig_hit = e[SRC_TIMER];
            TRIG_PWM: trig_hit = e[SRC_PWM];
            TRIG_ALWAYS: trig_hit = 1'b1;
            default: trig_hit = 1'b0;
        endcase
    endfunction : trig_hit

    function automatic logic [2:0] wrap(input logic [2:0] p, input logic [1:0] i);
        wrap = ({1'b0, p} == asq_depth(i) - 4'h1) ? 3'h0 : p + 3'h1;
    endfunction : wrap

    // ****************************************************************
    // Next state.
    // ****************************************************************
    always_comb begin
        s_nxt = s_r;
        push = 4'h0;
        pop = 4'h0;
        sw_set = 4'h0;
        rd = 32'h0000_0000;
        found = 1'b0;
        best = 2'h0;
        bestp = 2'h3;
        acc_sum = s_r.acc + {6'h00, conv_result};
        avg_n = 7'h01 << s_r.avg;
        avg_val = 10'(acc_sum >> s_r.avg);
        nib_mux = s_r.mux[s_r.cur][{s_r.step, 2'b00} +: 4];
        nib_ctl = s_r.ctl[s_r.cur][{s_r.step, 2'b00} +: 4];
        bm = s_r.w_d & byte_mask(s_r.w_s);
        wm = 32'h0000_0000;
        q = s_r.aw_a[6:5];
        s_nxt.cmd.start = 1'b0;

        // Trigger pins pass two flops before the edge detector.
        s_nxt.sy1 = trig_src;
        s_nxt.sy2 = s_r.sy1;
        s_nxt.sy3 = s_r.sy2;
        ev = s_r.sy2 & ~s_r.sy3;

        // Bus write channel.
        if (awvalid && s_r.awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.aw_a = awaddr;
        end
        if (wvalid && s_r.wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.w_d = wdata;
            s_nxt.w_s = wstrb;
        end
        if (bready && s_r.bvalid) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_OKAY;
            case (s_r.aw_a)
                OFF_ACTIVE: begin
                    wm = (s_r.w_d & bm) | ({28'h000_0000, s_r.run} & ~byte_mask(s_r.w_s));
                    s_nxt.run = wm[3:0];
                end
                OFF_MASK: begin
                    wm = bm | ({28'h000_0000, s_r.mask} & ~byte_mask(s_r.w_s));
                    s_nxt.mask = wm[3:0];
                end
                // RULE_18: write one clears
                OFF_MASKED: s_nxt.raw = s_r.raw & ~bm[3:0];
                // RULE_12: status clear lanes
                OFF_OVF: s_nxt.ovf = s_r.ovf & ~bm[3:0];
                OFF_UNF: s_nxt.unf = s_r.unf & ~bm[3:0];
                OFF_TRIG: begin
                    wm = bm | ({16'h0000, s_r.trig_sel} & ~byte_mask(s_r.w_s));
                    s_nxt.trig_sel = wm[15:0];
                end
                // RULE_21: priority field update
                OFF_PRIO: begin
                    wm = bm | ({16'h0000, s_r.prio} & ~byte_mask(s_r.w_s));
                    s_nxt.prio = wm[15:0] & PRIO_MASK;
                end
                // RULE_23: software initiate bits
                OFF_SWINIT: sw_set = bm[3:0] & s_r.run;
                // RULE_19: averaging ratio select
                OFF_AVG: begin
                    if (s_r.w_s[0]) begin
                        s_nxt.avg = (s_r.w_d[2:0] > AVG_MAX) ? AVG_MAX : s_r.w_d[2:0];
                    end
                end
                OFF_RAW: s_nxt.bresp = RESP_OKAY;
                default: begin
                    // RULE_03: step nibble registers
                    // RULE_06: writable while stopped
                    if (seq_hit(s_r.aw_a) && s_r.aw_a[4:2] == SEQ_MUX) begin
                        wm = bm | (s_r.mux[q] & ~byte_mask(s_r.w_s));
                        s_nxt.mux[q] = wm & asq_step_mask(q);
                    end else if (seq_hit(s_r.aw_a) && s_r.aw_a[4:2] == SEQ_CTL) begin
                        wm = bm | (s_r.ctl[q] & ~byte_mask(s_r.w_s));
                        s_nxt.ctl[q] = wm & asq_step_mask(q);
                    end else if (!(seq_hit(s_r.aw_a) && s_r.aw_a[4:3] == 2'b00)) begin
                        s_nxt.bresp = RESP_SLVERR;
                    end
                end
            endcase
        end

        // Bus read channel.
        if (rready && s_r.rvalid) begin
            s_nxt.rvalid = 1'b0;
        end
        if (arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = RESP_OKAY;
            case (araddr)
                OFF_ACTIVE: rd = {28'h000_0000, s_r.run};
                // RULE_16: unmasked raw view
                OFF_RAW: rd = {28'h000_0000, s_r.raw};
                OFF_MASK: rd = {28'h000_0000, s_r.mask};
                // RULE_17: raw AND mask
                OFF_MASKED: rd = {28'h000_0000, s_r.raw & s_r.mask};
                OFF_OVF: rd = {28'h000_0000, s_r.ovf};
                OFF_UNF: rd = {28'h000_0000, s_r.unf};
                OFF_TRIG: rd = {16'h0000, s_r.trig_sel};
                OFF_PRIO: rd = {16'h0000, s_r.prio};
                OFF_SWINIT: rd = 32'h0000_0000;
                OFF_AVG: rd = {29'h0000_0000, s_r.avg};
                default: begin
                    if (seq_hit(araddr)) begin
                        case (araddr[4:2])
                            SEQ_MUX: rd = s_r.mux[araddr[6:5]];
                            SEQ_CTL: rd = s_r.ctl[araddr[6:5]];
                            // RULE_10: pop oldest entry
                            SEQ_FIFO: begin
                                // RULE_25: empty read flags
                                if (s_r.cnt[araddr[6:5]] == 4'h0) begin
                                    s_nxt.unf[araddr[6:5]] = 1'b1;
                                end else begin
                                    // RULE_02: ten bits low
                                    rd = {22'h00_0000,
                                        s_r.mem[araddr[6:5]][s_r.tail[araddr[6:5]]]};
                                    pop[araddr[6:5]] = 1'b1;
                                end
                            end
                            // RULE_11: pointer and flag view
                            SEQ_FSTAT: begin
                                rd[FSTAT_TAIL_LSB +: 3] = s_r.tail[araddr[6:5]];
                                rd[FSTAT_HEAD_LSB +: 3] = s_r.head[araddr[6:5]];
                                rd[FSTAT_EMPTY] = (s_r.cnt[araddr[6:5]] == 4'h0);
                                rd[FSTAT_FULL] = (s_r.cnt[araddr[6:5]] ==
                                    asq_depth(araddr[6:5]));
                            end
                            default: s_nxt.rresp = RESP_SLVERR;
                        endcase
                    end else begin
                        s_nxt.rresp = RESP_SLVERR;
                    end
                end
            endcase
            s_nxt.rdata = rd;
        end

        // Sequencer engine.
        case (s_r.fsm)
            ST_IDLE: begin
                // RULE_21: lowest value wins
                for (int i = 0; i < 4; i++) begin
                    if (s_r.pend[i] && s_r.run[i] &&
                        (!found || s_r.prio[4*i +: 2] < bestp)) begin
                        found = 1'b1;
                        best = 2'(i);
                        bestp = s_r.prio[4*i +: 2];
                    end
                end
                if (found) begin
                    // RULE_26: restart at step zero
                    s_nxt.cur = best;
                    s_nxt.pend[best] = 1'b0;
                    s_nxt.step = 3'h0;
                    s_nxt.avg_cnt = 7'h00;
                    s_nxt.acc = 16'h0000;
                    s_nxt.fsm = ST_START;
                end
            end
            ST_START: begin
                // RULE_04: input select drive
                // RULE_07: repeats are allowed
                // RULE_22: pair maps to even input
                s_nxt.cmd.start = 1'b1;
                s_nxt.cmd.chan = nib_ctl[CTL_DIFF] ? {nib_mux[1:0], 1'b0} : nib_mux[2:0];
                // RULE_05: control flag decode
                // RULE_14: temperature sensor select
                s_nxt.cmd.diff = nib_ctl[CTL_DIFF];
                s_nxt.cmd.temp = nib_ctl[CTL_TEMP];
                s_nxt.fsm = ST_WAIT;
            end
            ST_WAIT: begin
                if (conv_done) begin
                    // RULE_19: accumulate then average
                    // RULE_24: off gives passthrough
                    if (s_r.avg_cnt + 7'h01 < avg_n) begin
                        s_nxt.acc = acc_sum;
                        s_nxt.avg_cnt = s_r.avg_cnt + 7'h01;
                        s_nxt.fsm = ST_START;
                    end else begin
                        s_nxt.acc = 16'h0000;
                        s_nxt.avg_cnt = 7'h00;
                        // RULE_25: full queue overflow
                        if (s_r.cnt[s_r.cur] == asq_depth(s_r.cur)) begin
                            s_nxt.ovf[s_r.cur] = 1'b1;
                        end else begin
                            s_nxt.mem[s_r.cur][s_r.head[s_r.cur]] = avg_val;
                            push[s_r.cur] = 1'b1;
                        end
                        // RULE_08: step raises raw
                        if (nib_ctl[CTL_IE]) begin
                            s_nxt.raw[s_r.cur] = 1'b1;
                        end
                        // RULE_09: stop at last step
                        // RULE_01: step limit per sequencer
                        if (nib_ctl[CTL_END] || !s_r.run[s_r.cur] ||
                            {1'b0, s_r.step} == asq_depth(s_r.cur) - 4'h1) begin
                            s_nxt.fsm = ST_IDLE;
                        end else begin
                            s_nxt.step = s_r.step + 3'h1;
                            s_nxt.fsm = ST_START;
                        end
                    end
                end
            end
            default: s_nxt.fsm = ST_IDLE;
        endcase

        // Queue pointers and counts.
        for (int i = 0; i < 4; i++) begin
            if (push[i]) begin
                s_nxt.head[i] = wrap(s_r.head[i], 2'(i));
            end
            if (pop[i]) begin
                s_nxt.tail[i] = wrap(s_r.tail[i], 2'(i));
            end
            s_nxt.cnt[i] = s_r.cnt[i] + {3'h0, push[i]} - {3'h0, pop[i]};
        end

        // RULE_20: trigger source select
        // RULE_06: only enabled sequencers
        for (int i = 0; i < 4; i++) begin
            if ((s_r.run[i] && trig_hit(s_r.trig_sel[4*i +: 4], ev)) || sw_set[i]) begin
                s_nxt.pend[i] = 1'b1;
            end
        end

        s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
        s_nxt.arready = !s_nxt.rvalid;
        // RULE_15: masked interrupt output
        s_nxt.irq = |(s_nxt.raw & s_nxt.mask);
    end

    // ****************************************************************
    // Registers.
    // ****************************************************************
    // RULE_13: single converter clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.prio <= PRIO_RST;
            s_r.avg <= AVG_OFF;
            s_r.fsm <= ST_IDLE;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign awready = s_r.awready;
    assign wready = s_r.wready;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign arready = s_r.arready;
    assign rvalid = s_r.rvalid;
    assign rresp = s_r.rresp;
    assign rdata = s_r.rdata;
    assign conv_cmd = s_r.cmd;
    assign irq = s_r.irq;

endmodule : asq_sequencer

`default_nettype wire

// ---- asq_pkg.sv ----
package asq_pkg;

    // ****************************************************************
    // Register byte offsets.
    // ****************************************************************
    localparam logic [11:0] OFF_ACTIVE = 12'h000;
    localparam logic [11:0] OFF_RAW = 12'h004;
    localparam logic [11:0] OFF_MASK = 12'h008;
    localparam logic [11:0] OFF_MASKED = 12'h00C;
    localparam logic [11:0] OFF_OVF = 12'h010;
    localparam logic [11:0] OFF_TRIG = 12'h014;
    localparam logic [11:0] OFF_UNF = 12'h018;
    localparam logic [11:0] OFF_PRIO = 12'h020;
    localparam logic [11:0] OFF_SWINIT = 12'h028;
    localparam logic [11:0] OFF_AVG = 12'h030;
    localparam logic [11:0] OFF_SEQ_BASE = 12'h080;
    localparam logic [2:0] SEQ_MUX = 3'h0;
    localparam logic [2:0] SEQ_CTL = 3'h1;
    localparam logic [2:0] SEQ_FIFO = 3'h2;
    localparam logic [2:0] SEQ_FSTAT = 3'h3;

    // ****************************************************************
    // Field positions and reset values.
    // ****************************************************************
    localparam int CTL_DIFF = 0;
    localparam int CTL_END = 1;
    localparam int CTL_IE = 2;
    localparam int CTL_TEMP = 3;
    localparam int FSTAT_TAIL_LSB = 0;
    localparam int FSTAT_HEAD_LSB = 4;
    localparam int FSTAT_EMPTY = 8;
    localparam int FSTAT_FULL = 12;
    localparam logic [15:0] PRIO_RST = 16'h3210;
    localparam logic [15:0] PRIO_MASK = 16'h3333;
    localparam logic [2:0] AVG_OFF = 3'h0;
    localparam logic [2:0] AVG_MAX = 3'h6;
    localparam int RES_W = 10;

    // ****************************************************************
    // Trigger codes and source bit positions.
    // ****************************************************************
    localparam logic [3:0] TRIG_SOFT = 4'h0;
    localparam logic [3:0] TRIG_COMP = 4'h1;
    localparam logic [3:0] TRIG_GPIO = 4'h4;
    localparam logic [3:0] TRIG_TIMER = 4'h5;
    localparam logic [3:0] TRIG_PWM = 4'h6;
    localparam logic [3:0] TRIG_ALWAYS = 4'hF;
    localparam int SRC_COMP = 0;
    localparam int SRC_GPIO = 1;
    localparam int SRC_TIMER = 2;
    localparam int SRC_PWM = 3;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_WAIT = 2'b10
    } asq_fsm_t;

    typedef struct packed {
        logic start;
        logic [2:0] chan;
        logic diff;
        logic temp;
    } asq_conv_cmd_t;

    // Steps and queue depth per sequencer.
    function automatic logic [3:0] asq_depth(input logic [1:0] i);
        case (i)
            2'h0: asq_depth = 4'h8;
            2'h3: asq_depth = 4'h1;
            default: asq_depth = 4'h4;
        endcase
    endfunction : asq_depth

    // Writable nibbles of the step registers.
    function automatic logic [31:0] asq_step_mask(input logic [1:0] i);
        case (i)
            2'h0: asq_step_mask = 32'hFFFF_FFFF;
            2'h3: asq_step_mask = 32'h0000_000F;
            default: asq_step_mask = 32'h0000_FFFF;
        endcase
    endfunction : asq_step_mask

endpackage : asq_pkg

// ---- asq_sequencer_props.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// Bus and converter checks.
// ****
module asq_sequencer_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire asq_pkg::asq_conv_cmd_t conv_cmd,
    input wire logic conv_done,
    input wire logic irq
);
    import asq_pkg::*;
    logic busy_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_r <= 1'b0;
        end else if (conv_cmd.start) begin
            busy_r <= 1'b1;
        end else if (conv_done) begin
            busy_r <= 1'b0;
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    AST_START_PULSE: assert property (conv_cmd.start |=> !conv_cmd.start)
        else $error("start pulse too long");
    AST_ONE_CONV: assert property (conv_cmd.start |-> !busy_r)
        else $error("start while busy");
    AST_CMD_HOLD: assert property (!conv_cmd.start |->
        $stable({conv_cmd.chan, conv_cmd.diff, conv_cmd.temp}))
        else $error("command moved");
    AST_RD_LAT: assert property (ce && arvalid && arready |=> rvalid)
        else $error("read answer late");
    AST_RD_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    AST_AR_BLOCK: assert property (rvalid |-> !arready)
        else $error("read taken while busy");
    AST_WR_LAT: assert property (ce && awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer late");
    AST_WR_BLOCK: assert property (bvalid |-> !(awready || wready))
        else $error("write taken while busy");
    cover property (conv_cmd.start);
    cover property (conv_done ##[1:4] irq);
    cover property (rvalid && rready);
endmodule : asq_sequencer_props
`default_nettype wire

// ---- asq_conv_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// Converter core model.
// ****
module asq_conv_model #(
    parameter int DELAY = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire asq_pkg::asq_conv_cmd_t conv_cmd,
    output logic conv_done,
    output logic [9:0] conv_result
);
    import asq_pkg::*;
    asq_conv_cmd_t cmd_r;
    logic [7:0] cnt_r;
    always_ff @(posedge aclk) begin
        conv_done <= 1'b0;
        conv_result <= ~conv_result;
        if (!aresetn) begin
            cnt_r <= 8'h00;
            conv_result <= 10'h000;
        end else if (conv_cmd.start) begin
            cnt_r <= 8'(DELAY);
            cmd_r <= conv_cmd;
        end else if (cnt_r == 8'h01) begin
            conv_done <= 1'b1;
            cnt_r <= 8'h00;
            conv_result <= cmd_r.temp ? 10'h3C0 : {3'b101, 2'b00, cmd_r.diff, 1'b0, cmd_r.chan};
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end
endmodule : asq_conv_model
`default_nettype wire

// ---- asq_sequencer_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// Register level bench.
// ****
module asq_sequencer_tb_top;
    import asq_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, d;
    logic [3:0] wstrb = 4'hF, trig_src = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, conv_done, irq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata;
    logic [9:0] conv_result;
    asq_conv_cmd_t conv_cmd;
    int n_fail = 0, check_count = 0, cyc = 0;
    logic [31:0] q [4] = '{32'h0000_03C0, 32'h0000_0285, 32'h0000_0285, 32'h0000_0292};
    always #5 aclk = ~aclk;
    asq_sequencer i_asq_sequencer (.aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .trig_src, .conv_cmd, .conv_done,
        .conv_result, .irq);
    asq_conv_model #(.DELAY(3)) i_asq_conv_model (.aclk, .aresetn, .conv_cmd, .conv_done,
        .conv_result);
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask : chk
    task automatic chkr(input logic [1:0] e, input logic [1:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask : chkr
    function automatic logic [11:0] sa(input logic [1:0] n, input logic [2:0] k);
        return OFF_SEQ_BASE + {5'h00, n, 5'h00} + {7'h00, k, 2'b00};
    endfunction : sa
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task automatic poll(input logic [11:0] a, input logic [31:0] m);
        int k;
        k = 0;
        do begin
            rd(a);
            k++;
        end while ((d & m) !== m && k < 200);
    endtask : poll
    task automatic pulse;
        trig_src <= 4'h4;
        repeat (3) @(posedge aclk);
        trig_src <= 4'h0;
        repeat (3) @(posedge aclk);
    endtask : pulse
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test;
        end
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(OFF_ACTIVE); chk(32'h0000_0000, d);
        rd(OFF_PRIO); chk(32'h0000_3210, d);
        rd(OFF_AVG); chk(32'h0000_0000, d);
        rd(sa(0, SEQ_FSTAT)); chk(32'h0000_0100, d);
        $display("reset test done");
        wr(sa(0, SEQ_MUX), 32'h0000_1553);
        wr(sa(0, SEQ_CTL), 32'h0000_7448);
        wr(OFF_MASK, 32'h0000_0001);
        wr(OFF_ACTIVE, 32'h0000_0001);
        wr(OFF_SWINIT, 32'h0000_0001);
        poll(sa(0, SEQ_FSTAT), 32'h0000_0040);
        chk(32'h0000_0040, d);
        chk(32'h0000_0001, {31'h0, irq});
        rd(OFF_RAW); chk(32'h0000_0001, d);
        rd(OFF_MASKED); chk(32'h0000_0001, d);
        wr(OFF_MASK, 32'h0000_0000);
        rd(OFF_RAW); chk(32'h0000_0001, d);
        rd(OFF_MASKED); chk(32'h0000_0000, d);
        chk(32'h0000_0000, {31'h0, irq});
        wr(OFF_MASK, 32'h0000_0001);
        wr(OFF_MASKED, 32'h0000_0000);
        rd(OFF_RAW); chk(32'h0000_0001, d);
        wr(OFF_MASKED, 32'h0000_0001);
        rd(OFF_RAW); chk(32'h0000_0000, d);
        for (int i = 0; i < 4; i++) begin
            rd(sa(0, SEQ_FIFO)); chk(q[i], d);
        end
        rd(sa(0, SEQ_FSTAT)); chk(32'h0000_0144, d);
        rd(sa(0, SEQ_FIFO));
        rd(OFF_UNF); chk(32'h0000_0001, d);
        rd(sa(0, SEQ_FSTAT)); chk(32'h0000_0144, d);
        wr(OFF_UNF, 32'h0000_0001);
        rd(OFF_UNF); chk(32'h0000_0000, d);
        $display("sequence test done");
        wr(OFF_TRIG, 32'h0000_5000);
        wr(sa(3, SEQ_MUX), 32'h0000_0004);
        wr(sa(3, SEQ_CTL), 32'h0000_0002);
        wr(OFF_ACTIVE, 32'h0000_0008);
        pulse;
        pulse;
        poll(OFF_OVF, 32'h0000_0008);
        chk(32'h0000_0008, d);
        rd(sa(3, SEQ_FIFO)); chk(32'h0000_0284, d);
        wr(OFF_OVF, 32'h0000_0008);
        rd(OFF_OVF); chk(32'h0000_0000, d);
        rd(12'h040); chkr(RESP_SLVERR, r);
        wr(12'h040, 32'h0000_0000); chkr(RESP_SLVERR, r);
        $display("trigger test done");
        end_of_test;
    end
endmodule : asq_sequencer_tb_top
bind asq_sequencer asq_sequencer_props i_asq_sequencer_props (.aclk, .aresetn, .ce,
    .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready, .rdata, .rvalid,
    .rready, .conv_cmd, .conv_done, .irq);
`default_nettype wire
